// *** rtl/pci_cfg_pkg.sv ***
package pci_cfg_pkg;

    // ****************************************
    // Option encodings
    // ****************************************
    localparam logic       SPACE_MEMORY        = 1'h0;
    localparam logic       SPACE_IO            = 1'h1;
    localparam logic       narrow_space_flag   = 1'h0;
    localparam logic       wide_space_flag     = 1'h1;
    localparam logic       OPT_DISABLE         = 1'h0;
    localparam logic       OPT_ENABLE          = 1'h1;
    localparam logic       PREFETCH_FLAG       = 1'h1;
    localparam logic       no_prefetch_flag    = 1'h0;
    localparam logic [1:0] placement_code_zero = 2'h0;
    localparam logic [1:0] PLACEMENT_CODE_ONE  = 2'h1;
    localparam logic [1:0] PLACEMENT_CODE_TWO  = 2'h2;
    localparam logic [1:0] IO_SPACE_CODE       = 2'h3;
    localparam logic [31:0] largest_size_mask  = 32'h8000_0000;
    localparam logic [31:0] smallest_size_mask = 32'hFFFF_FFF0;

    // ****************************************
    // Vector layout
    // ****************************************
    localparam int CFG_W          = 256;
    localparam int DATA_W         = 32;
    localparam int ID_LSB         = 120;
    localparam int CLASS_LSB      = 152;
    localparam int SUBSYS_LSB     = 184;
    localparam int EXT_SUBSYS_BIT = 114;
    localparam int FIFO_DEPTH     = 8;

    // ****************************************
    // Header word selectors
    // ****************************************
    localparam logic [1:0] SEL_IDENTITY = 2'h0;
    localparam logic [1:0] SEL_CLASS    = 2'h1;
    localparam logic [1:0] SEL_SUBSYS   = 2'h2;

    localparam logic [31:0] CLASS_RESET = 32'h0B40_0000;

endpackage : pci_cfg_pkg

// *** rtl/data_fifo.sv ***
`timescale 1ns/1ps
module data_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    nxt_wr;
    logic [AW-1:0]    rd_ff;
    logic [AW-1:0]    nxt_rd;
    logic [AW:0]      cnt_ff;
    logic [AW:0]      nxt_cnt;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        nxt_wr  = push ? AW'(wr_ff + 1'b1) : wr_ff;
        nxt_rd  = pop ? AW'(rd_ff + 1'b1) : rd_ff;
        nxt_cnt = cnt_ff;
        if (push && !pop)
            nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
        else if (pop && !push)
            nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem_ff[wr_ff] <= in_data;
    end
endmodule : data_fifo

// *** rtl/pci_core_cfg_and_pipeline.sv ***
`timescale 1ns/1ps
module pci_core_cfg_and_pipeline
    import pci_cfg_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          srst,
    // Configuration vector and external subsystem word
    input  wire logic [pci_cfg_pkg::CFG_W-1:0] cfg_vector,
    input  wire logic [pci_cfg_pkg::DATA_W-1:0] ext_subsys_data,
    // Bus side, received
    input  wire logic [pci_cfg_pkg::DATA_W-1:0] bus_ad_in,
    input  wire logic                          bus_master_phase,
    input  wire logic                          bus_target_phase,
    input  wire logic                          bus_data_phase,
    input  wire logic                          bus_addr_phase,
    // Bus side, driven
    output logic      [pci_cfg_pkg::DATA_W-1:0] bus_ad_out,
    output logic                               bus_ad_oe_n,
    input  wire logic                          bus_ready,
    // Header reads
    input  wire logic [1:0]                    hdr_sel,
    output logic      [pci_cfg_pkg::DATA_W-1:0] hdr_data,
    // User side
    output logic      [pci_cfg_pkg::DATA_W-1:0] shared_addr_data_bus,
    output logic                               master_data_valid,
    output logic                               target_data_valid,
    output logic                               decoded_addr_strobe,
    output logic                               master_source_enable,
    output logic                               target_source_enable,
    input  wire logic                          master_addr_oe_n,
    input  wire logic [pci_cfg_pkg::DATA_W-1:0] user_start_addr,
    input  wire logic [pci_cfg_pkg::DATA_W-1:0] user_wr_data,
    input  wire logic                          user_wr_valid,
    output logic                               user_wr_ready,
    output logic                               ext_subsys_en,
    output logic                               cfg_vendor_reserved
);
    import pci_cfg_pkg::*;

    // ****************************************
    // Input capture stage
    // ****************************************
    logic [DATA_W-1:0] nxt_rx_data;
    logic              rx_mvld_ff;
    logic              nxt_rx_mvld;
    logic              rx_tvld_ff;
    logic              nxt_rx_tvld;
    logic              rx_avld_ff;
    logic              nxt_rx_avld;
    logic              src_m_ff;
    logic              nxt_src_m;
    logic              src_t_ff;
    logic              nxt_src_t;

    always_comb
    begin
        nxt_rx_data = bus_ad_in;
        nxt_rx_mvld = bus_master_phase && bus_data_phase;
        nxt_rx_tvld = bus_target_phase && bus_data_phase;
        nxt_rx_avld = bus_addr_phase;
        nxt_src_m   = bus_master_phase && !bus_data_phase;
        nxt_src_t   = bus_target_phase && !bus_data_phase;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rx_mvld_ff <= 1'b0;
            rx_tvld_ff <= 1'b0;
            rx_avld_ff <= 1'b0;
            src_m_ff   <= 1'b0;
            src_t_ff   <= 1'b0;
        end
        else
        begin
            rx_mvld_ff <= nxt_rx_mvld;
            rx_tvld_ff <= nxt_rx_tvld;
            rx_avld_ff <= nxt_rx_avld;
            src_m_ff   <= nxt_src_m;
            src_t_ff   <= nxt_src_t;
        end
    end

    // ****************************************
    // User-side outputs
    // ****************************************
    logic [DATA_W-1:0] shared_ff;
    logic [DATA_W-1:0] nxt_shared;

    // Start address takes the shared bus while its enable is low
    always_comb
    begin
        if (!master_addr_oe_n)
            nxt_shared = user_start_addr;
        else
            nxt_shared = nxt_rx_data;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            shared_ff <= '0;
        else
            shared_ff <= nxt_shared;
    end

    assign shared_addr_data_bus = shared_ff;
    assign master_data_valid    = rx_mvld_ff;
    assign target_data_valid    = rx_tvld_ff;
    assign decoded_addr_strobe  = rx_avld_ff;
    assign master_source_enable = src_m_ff;
    assign target_source_enable = src_t_ff;

    // ****************************************
    // Transmit path through FIFO
    // ****************************************
    logic [DATA_W-1:0] fifo_data;
    logic              fifo_valid;
    logic              fifo_pop;
    logic [DATA_W-1:0] tx_ff;
    logic [DATA_W-1:0] nxt_tx;
    logic              tx_oe_n_ff;
    logic              nxt_tx_oe_n;
    logic              fifo_in_ready;

    data_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_data   (user_wr_data),
        .in_valid  (user_wr_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    assign fifo_pop = bus_ready;

    // Words leave through an output flop, one stage after the FIFO head
    always_comb
    begin
        nxt_tx      = tx_ff;
        nxt_tx_oe_n = 1'b1;
        if (fifo_valid && fifo_pop)
        begin
            nxt_tx      = fifo_data;
            nxt_tx_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tx_ff      <= '0;
            tx_oe_n_ff <= 1'b1;
        end
        else
        begin
            tx_ff      <= nxt_tx;
            tx_oe_n_ff <= nxt_tx_oe_n;
        end
    end

    assign bus_ad_out    = tx_ff;
    assign bus_ad_oe_n   = tx_oe_n_ff;
    assign user_wr_ready = fifo_in_ready;

    // ****************************************
    // Configuration header decode
    // ****************************************
    logic [DATA_W-1:0] id_word;
    logic [DATA_W-1:0] class_word;
    logic [DATA_W-1:0] subsys_word;
    logic              ext_en;
    logic [DATA_W-1:0] hdr_ff;
    logic [DATA_W-1:0] nxt_hdr;
    logic              ext_ff;
    logic              vres_ff;

    always_comb
    begin
        id_word     = cfg_vector[ID_LSB +: DATA_W];
        class_word  = cfg_vector[CLASS_LSB +: DATA_W];
        ext_en      = (cfg_vector[EXT_SUBSYS_BIT] == OPT_ENABLE);
        if (ext_en)
            subsys_word = ext_subsys_data;
        else
            subsys_word = cfg_vector[SUBSYS_LSB +: DATA_W];
        nxt_hdr = '0;
        if (hdr_sel == SEL_IDENTITY)
            nxt_hdr = id_word;
        else if (hdr_sel == SEL_CLASS)
            nxt_hdr = class_word;
        else if (hdr_sel == SEL_SUBSYS)
            nxt_hdr = subsys_word;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            hdr_ff  <= '0;
            ext_ff  <= 1'b0;
            vres_ff <= 1'b0;
        end
        else
        begin
            hdr_ff  <= nxt_hdr;
            ext_ff  <= ext_en;
            vres_ff <= (id_word[15:0] == 16'hFFFF);
        end
    end

    assign hdr_data            = hdr_ff;
    assign ext_subsys_en       = ext_ff;
    assign cfg_vendor_reserved = vres_ff;

endmodule : pci_core_cfg_and_pipeline

// *** testbench/cfg_pipe_monitor.sv ***
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module cfg_pipe_monitor
    import pci_cfg_pkg::*;
(
    input wire logic                           clk,
    input wire logic                           srst,
    input wire logic [pci_cfg_pkg::CFG_W-1:0]  cfg_vector,
    input wire logic [pci_cfg_pkg::DATA_W-1:0] ext_subsys_data,
    input wire logic [pci_cfg_pkg::DATA_W-1:0] bus_ad_in,
    input wire logic                           bus_master_phase,
    input wire logic                           bus_data_phase,
    input wire logic                           bus_addr_phase,
    input wire logic                           bus_ad_oe_n,
    input wire logic                           bus_ready,
    input wire logic [1:0]                     hdr_sel,
    input wire logic [pci_cfg_pkg::DATA_W-1:0] hdr_data,
    input wire logic [pci_cfg_pkg::DATA_W-1:0] shared_addr_data_bus,
    input wire logic                           master_data_valid,
    input wire logic                           decoded_addr_strobe,
    input wire logic                           master_source_enable,
    input wire logic                           master_addr_oe_n,
    input wire logic [pci_cfg_pkg::DATA_W-1:0] user_start_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_rx_word_late: assert property (master_addr_oe_n |=> shared_addr_data_bus == $past(bus_ad_in))
        else $error("received word not one cycle late");
    a_start_addr_gate: assert property (!master_addr_oe_n |=> shared_addr_data_bus == $past(user_start_addr))
        else $error("start address not placed");
    a_master_valid_late: assert property (bus_master_phase && bus_data_phase |=> master_data_valid)
        else $error("master valid missing");
    a_addr_strobe_late: assert property (bus_addr_phase |=> decoded_addr_strobe)
        else $error("address strobe missing");
    a_source_enable: assert property (bus_master_phase && !bus_data_phase |=> master_source_enable)
        else $error("master source enable missing");
    a_identity_word: assert property (hdr_sel == 2'h0 |=> hdr_data == $past(cfg_vector[151:120]))
        else $error("identity word wrong");
    a_class_word: assert property (hdr_sel == 2'h1 |=> hdr_data == $past(cfg_vector[183:152]))
        else $error("class word wrong");
    a_subsys_fixed: assert property (hdr_sel == 2'h2 && !cfg_vector[114] |=> hdr_data == $past(cfg_vector[215:184]))
        else $error("subsystem word wrong");
    a_subsys_external: assert property (hdr_sel == 2'h2 && cfg_vector[114] |=> hdr_data == $past(ext_subsys_data))
        else $error("external subsystem word wrong");
    a_tx_after_ready: assert property (!bus_ad_oe_n |-> $past(bus_ready))
        else $error("word sent without bus ready");

    c_rx_master: cover property (master_data_valid);
    c_tx_word: cover property (!bus_ad_oe_n);
    c_ext_read: cover property (hdr_sel == 2'h2 && cfg_vector[114]);
endmodule : cfg_pipe_monitor

bind pci_core_cfg_and_pipeline cfg_pipe_monitor mon (.*);

// *** testbench/bus_agent_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Far-side bus agent and sink
// ****************************************
module bus_agent_model
    import pci_cfg_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           go,
    input  wire logic [1:0]                     kind,
    input  wire logic [pci_cfg_pkg::DATA_W-1:0] word,
    input  wire logic                           sink_en,
    output logic      [pci_cfg_pkg::DATA_W-1:0] bus_ad_in,
    output logic                                bus_master_phase,
    output logic                                bus_target_phase,
    output logic                                bus_data_phase,
    output logic                                bus_addr_phase,
    output logic                                bus_ready
);
    logic [DATA_W-1:0] last_ff = '0;
    logic              tog_ff  = 1'b0;

    // Set up ahead of the edge; idle bus shows inverse of last word
    assign bus_ad_in        = go ? word : ~last_ff;
    assign bus_master_phase = go & ~kind[0];
    assign bus_target_phase = go & kind[0];
    assign bus_data_phase   = go & ~kind[1];
    assign bus_addr_phase   = go & kind[1];
    // Slow sink, every other cycle
    assign bus_ready        = sink_en & tog_ff;
    always @(posedge clk) last_ff <= bus_ad_in;
    always @(negedge clk) tog_ff <= ~tog_ff;
endmodule : bus_agent_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module testbench;
    import pci_cfg_pkg::*;
    // Arbitrary identity values
    localparam logic [31:0] ID_WORD  = 32'h5A3C_1234;
    localparam logic [31:0] SUB_WORD = 32'h0077_1234;
    logic         clk = 1'b0, srst = 1'b1, go = 1'b0, sink_en = 1'b0;
    logic [255:0] cfg_vector = '0;
    logic [31:0]  ext_subsys_data = '0, user_start_addr = '0, user_wr_data = '0, word = '0;
    logic [31:0]  bus_ad_in, bus_ad_out, hdr_data, shared_addr_data_bus;
    logic [1:0]   hdr_sel = 2'h0, kind = 2'h0;
    logic         master_addr_oe_n = 1'b1, user_wr_valid = 1'b0;
    logic         bus_master_phase, bus_target_phase, bus_data_phase, bus_addr_phase, bus_ready;
    logic         bus_ad_oe_n, master_data_valid, target_data_valid, decoded_addr_strobe;
    logic         master_source_enable, target_source_enable, user_wr_ready, ext_subsys_en;
    logic         cfg_vendor_reserved;
    int           n_mismatch = 0, cmp_count = 0;

    pci_core_cfg_and_pipeline dut (.*);
    bus_agent_model model (.*);

    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic do_reset(input logic ext);
        srst = 1'b1;
        cfg_vector[114] = ext;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        chk(bus_ad_oe_n, 1'b1, "idle enable");
        chk(hdr_data, 32'h0, "header after reset");
    endtask : do_reset

    task automatic hdr_read(input logic [1:0] sel, input logic [31:0] exp);
        hdr_sel = sel;
        @(negedge clk);
        chk(hdr_data, exp, "header word");
    endtask : hdr_read

    task automatic rx_burst();
        logic [4:0] flags;
        go = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            kind = k[1:0];
            word = 32'h1357_0000 | k;
            flags = {k == 0, k == 1, k > 1, k == 2, k == 3};
            @(negedge clk);
            chk(shared_addr_data_bus, 32'h1357_0000 | k, "received word");
            chk({master_data_valid, target_data_valid, decoded_addr_strobe,
                 master_source_enable, target_source_enable}, flags, "strobes");
        end
        go = 1'b0;
    endtask : rx_burst

    task automatic start_addr();
        master_addr_oe_n = 1'b0;
        user_start_addr = 32'h2468_ACE0;
        @(negedge clk);
        master_addr_oe_n = 1'b1;
        chk(shared_addr_data_bus, 32'h2468_ACE0, "start address");
    endtask : start_addr

    task automatic fifo_fill_drain();
        int n;
        int k;
        user_wr_valid = 1'b1;
        for (n = 0; n < 12 && user_wr_ready === 1'b1; n++)
        begin
            user_wr_data = 32'hC0DE_0000 + 32'(n);
            @(negedge clk);
        end
        user_wr_valid = 1'b0;
        chk(n, FIFO_DEPTH, "words held");
        sink_en = 1'b1;
        k = 0;
        for (n = 0; n < 40 && k < FIFO_DEPTH; n++)
        begin
            @(negedge clk);
            if (bus_ad_oe_n === 1'b0)
            begin
                chk(bus_ad_out, 32'hC0DE_0000 + 32'(k), "sent word");
                k++;
            end
        end
        sink_en = 1'b0;
        if (k != FIFO_DEPTH)
        begin
            n_mismatch++;
            $display("mismatch at %0t: drain timed out", $time);
        end
        chk(user_wr_ready, 1'b1, "drained");
    endtask : fifo_fill_drain

    initial
    begin
        cfg_vector[151:120] = ID_WORD;
        cfg_vector[183:152] = CLASS_RESET;
        cfg_vector[215:184] = SUB_WORD;
        cfg_vector[35:34] = placement_code_zero;
        cfg_vector[32:1] = smallest_size_mask;
        cfg_vector[36] = SPACE_MEMORY;
        do_reset(OPT_DISABLE);
        chk(user_wr_ready, 1'b1, "ready after reset");
        hdr_read(SEL_IDENTITY, ID_WORD);
        chk(cfg_vendor_reserved, 1'b0, "vendor code usable");
        hdr_read(SEL_CLASS, 32'h0B40_0000);
        hdr_read(SEL_SUBSYS, SUB_WORD);
        hdr_read(2'h3, 32'h0);
        rx_burst();
        start_addr();
        fifo_fill_drain();
        do_reset(OPT_ENABLE);
        ext_subsys_data = 32'h0055_1234;
        hdr_read(SEL_SUBSYS, 32'h0055_1234);
        ext_subsys_data = 32'h0066_1234;
        hdr_read(SEL_SUBSYS, 32'h0066_1234);
        chk(ext_subsys_en, 1'b1, "external option");
        hdr_read(SEL_IDENTITY, ID_WORD);
        report_and_stop();
    end
endmodule : testbench
